// File: hw/dmc_params.svh
// Purpose: constants of the display mode and cursor register bank
// Assumes: included by its bare name
// Notes: definitions only
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

// ****************************************
// indexed port decode
// ****************************************
`define DMC_PORT_MONO_HI 12'h03B
`define DMC_PORT_COLR_HI 12'h03D
`define DMC_PORT_INDEX_LO 4'h4
`define DMC_PORT_DATA_LO 4'h5

// ****************************************
// register indices
// ****************************************
`define DMC_IDX_LOCK2 8'h39
`define DMC_IDX_MODE_CTL 8'h42
`define DMC_IDX_EXTENDED_DISPLAY_MODE 8'h43
`define DMC_IDX_CUR_MODE 8'h45
`define DMC_IDX_ORGX_HI 8'h46
`define DMC_IDX_ORGX_LO 8'h47
`define DMC_IDX_ORGY_HI 8'h48
`define DMC_IDX_ORGY_LO 8'h49
`define DMC_IDX_FG_STACK 8'h4A
`define DMC_IDX_BG_STACK 8'h4B
`define DMC_IDX_STA_HI 8'h4C
`define DMC_IDX_STA_LO 8'h4D
`define DMC_IDX_PAT_X 8'h4E
`define DMC_IDX_PAT_Y 8'h4F

// ****************************************
// reset values and writable masks
// ****************************************
`define DMC_RST_BYTE 8'h00
`define DMC_MASK_MODE_CTL 8'h2F
`define DMC_MASK_EXTENDED_DISPLAY_MODE 8'h9F
`define DMC_MASK_CUR_MODE 8'h3D
`define DMC_MASK_HI3 8'h07
`define DMC_MASK_HI4 8'h0F
`define DMC_MASK_PAT 8'h3F
`define DMC_LOCK_KEY 3'h5

// ****************************************
// field positions
// ****************************************
`define DMC_B_INTERLACE 5
`define DMC_B_DUAL_EDGE 0
`define DMC_B_DAC_SEL2 1
`define DMC_B_WIDTH8 2
`define DMC_B_COLOUR16 3
`define DMC_B_PORT_XLATE 4
`define DMC_B_HDOUBLE 7
`define DMC_B_CUR_EN 0
`define DMC_B_STRETCH2 2
`define DMC_B_STRETCH3 3
`define DMC_B_RIGHT_STORE 4
`define DMC_B_REMAP 5

// ****************************************
// enhanced port decode and stack depth
// ****************************************
`define DMC_ENH_PORT 10'h2E8
`define DMC_ENH_XOR 10'h3A0
`define DMC_STACK_DEPTH 3
`define DMC_STACK_LAST 2'h2

`endif

// File: hw/dmc_pkg.sv
// Purpose: shared types of the display mode and cursor register bank
// Assumes: constants live in dmc_params.svh
// Notes: types only
package dmc_pkg;

  // one host cycle on the indexed io port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmc_io_req_t;

  // true-colour stack contents, entry 0 in the low byte
  typedef struct packed {
    logic [23:0] fg;
    logic [23:0] bg;
  } dmc_colour_t;

  // stack port commands
  typedef struct packed {
    logic wr_fg;
    logic wr_bg;
    logic ptr_clr;
    logic [7:0] wdata;
  } dmc_stack_cmd_t;

endpackage

// File: hw/dmc_colour_stack.sv
// Purpose: foreground and background true-colour stacks with one pointer
// Assumes: one write or pointer clear per cycle from the register bank
// Notes: pointer wraps from entry 2 back to entry 0
`timescale 1ns/10ps
`default_nettype none
`include "dmc_params.svh"

module dmc_colour_stack (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire dmc_pkg::dmc_stack_cmd_t i_cmd,
  output logic [7:0] o_fg_rdata,
  output logic [7:0] o_bg_rdata,
  output dmc_pkg::dmc_colour_t o_colour
);

  logic [1:0] ptr_q;
  logic [7:0] fg_q [`DMC_STACK_DEPTH];
  logic [7:0] bg_q [`DMC_STACK_DEPTH];

  // ****************************************
  // shared pointer
  // ****************************************
  // a clear and a write never meet: they come from different indices
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ptr_q <= 2'h0;
    end else if (i_cmd.ptr_clr) begin
      ptr_q <= 2'h0;
    end else if (i_cmd.wr_fg || i_cmd.wr_bg) begin
      ptr_q <= (ptr_q == `DMC_STACK_LAST) ? 2'h0 : ptr_q + 2'h1;
    end
  end

  // ****************************************
  // stack entries
  // ****************************************
  genvar e;
  generate
    for (e = 0; e < `DMC_STACK_DEPTH; e++) begin : g_entry
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          fg_q[e] <= `DMC_RST_BYTE;
          bg_q[e] <= `DMC_RST_BYTE;
        end else begin
          if (i_cmd.wr_fg && ptr_q == 2'(e)) begin
            fg_q[e] <= i_cmd.wdata;
          end
          if (i_cmd.wr_bg && ptr_q == 2'(e)) begin
            bg_q[e] <= i_cmd.wdata;
          end
        end
      end
      assign o_colour.fg[8*e +: 8] = fg_q[e];
      assign o_colour.bg[8*e +: 8] = bg_q[e];
    end
  endgenerate

  // reads show the entry under the pointer without moving it
  assign o_fg_rdata = (ptr_q == `DMC_STACK_LAST) ? fg_q[2] :
                      (ptr_q == 2'h1) ? fg_q[1] : fg_q[0];
  assign o_bg_rdata = (ptr_q == `DMC_STACK_LAST) ? bg_q[2] :
                      (ptr_q == 2'h1) ? bg_q[1] : bg_q[0];

endmodule
`default_nettype wire

// File: hw/dmc_regs.sv
// Purpose: indexed control registers for extended display modes and cursor
// Assumes: host io cycles are one-cycle strobes synchronous to i_ref_clk
// Notes: index port at 3B4/3D4, data port at 3B5/3D5
`timescale 1ns/10ps
`default_nettype none
`include "dmc_params.svh"

module dmc_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire dmc_pkg::dmc_io_req_t i_io,
  input wire logic [1:0] i_dac_select_ext,
  input wire logic [1:0] i_screen_width_ext,
  input wire logic i_ext_cursor_enable,
  input wire logic i_enhanced_mode,
  input wire logic [1:0] i_cursor_pixel_data,
  input wire logic i_odd_field,
  input wire logic i_cursor_data_valid,
  output logic [7:0] o_io_rdata,
  output logic o_io_rd_ack,
  output logic o_unlocked,
  output logic o_interlace_select,
  output logic o_pixel_clock_dual_edge,
  output logic o_dac_select_bit2,
  output logic o_screen_width_bit8,
  output logic o_sixteen_bit_colour_enable,
  output logic o_port_translate_enable,
  output logic [9:0] o_enhanced_port,
  output logic o_horizontal_count_double,
  output logic o_cursor_visible,
  output logic [1:0] o_cursor_width_factor,
  output logic o_truecolour_use,
  output logic o_cursor_right_storage,
  output logic o_storage_align_error,
  output logic [10:0] o_cursor_left_coordinate,
  output logic [10:0] o_cursor_top_coordinate,
  output logic [11:0] o_cursor_storage_start,
  output logic [5:0] o_pattern_offset_horizontal,
  output logic [5:0] o_pattern_offset_vertical,
  output dmc_pkg::dmc_colour_t o_colour,
  output logic [1:0] o_cursor_pixel_outputs,
  output logic o_cursor_pins_oe_n
);

  // ****************************************
  // port decode
  // ****************************************
  logic base_hit;
  logic idx_wr;
  logic idx_rd;
  logic dat_wr;
  logic dat_rd;
  logic [7:0] index_q;
  logic [7:0] lock2_q;
  logic unlocked;
  logic bank_idx;
  logic acc_wr;
  logic acc_rd;

  assign base_hit = (i_io.addr[15:4] == `DMC_PORT_MONO_HI) ||
                    (i_io.addr[15:4] == `DMC_PORT_COLR_HI);
  assign idx_wr = i_io.wr && base_hit && (i_io.addr[3:0] == `DMC_PORT_INDEX_LO);
  assign idx_rd = i_io.rd && base_hit && (i_io.addr[3:0] == `DMC_PORT_INDEX_LO);
  assign dat_wr = i_io.wr && base_hit && (i_io.addr[3:0] == `DMC_PORT_DATA_LO);
  assign dat_rd = i_io.rd && base_hit && (i_io.addr[3:0] == `DMC_PORT_DATA_LO);

  // only the key bits 7-5 matter, so any change to them relocks
  assign unlocked = (lock2_q[7:5] == `DMC_LOCK_KEY);
  assign bank_idx = (index_q >= `DMC_IDX_MODE_CTL) && (index_q <= `DMC_IDX_PAT_Y) &&
                    (index_q != 8'h44);
  assign acc_wr = dat_wr && unlocked && bank_idx;
  assign acc_rd = dat_rd && unlocked && bank_idx;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      index_q <= `DMC_RST_BYTE;
    end else if (idx_wr) begin
      index_q <= i_io.wdata;
    end
  end

  // the lock register itself is always reachable
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lock2_q <= `DMC_RST_BYTE;
    end else if (dat_wr && index_q == `DMC_IDX_LOCK2) begin
      lock2_q <= i_io.wdata;
    end
  end

  function automatic logic wr_at(input logic [7:0] idx);
    wr_at = acc_wr && (index_q == idx);
  endfunction

  // ****************************************
  // mode registers
  // ****************************************
  logic [7:0] mode_ctl_q;
  logic [7:0] extended_display_mode_q;
  logic [7:0] cur_mode_q;

  // reserved bits are dropped on write and read as zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_ctl_q <= `DMC_RST_BYTE;
    end else if (wr_at(`DMC_IDX_MODE_CTL)) begin
      mode_ctl_q <= i_io.wdata & `DMC_MASK_MODE_CTL;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      extended_display_mode_q <= `DMC_RST_BYTE;
    end else if (wr_at(`DMC_IDX_EXTENDED_DISPLAY_MODE)) begin
      extended_display_mode_q <= i_io.wdata & `DMC_MASK_EXTENDED_DISPLAY_MODE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cur_mode_q <= `DMC_RST_BYTE;
    end else if (wr_at(`DMC_IDX_CUR_MODE)) begin
      cur_mode_q <= i_io.wdata & `DMC_MASK_CUR_MODE;
    end
  end

  // ****************************************
  // cursor origin, staged then applied
  // ****************************************
  logic [2:0] orgx_hi_q;
  logic [7:0] orgx_lo_q;
  logic [2:0] orgy_hi_q;
  logic [7:0] orgy_lo_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      orgx_hi_q <= 3'h0;
      orgx_lo_q <= `DMC_RST_BYTE;
      orgy_hi_q <= 3'h0;
      orgy_lo_q <= `DMC_RST_BYTE;
    end else begin
      if (wr_at(`DMC_IDX_ORGX_HI)) begin
        orgx_hi_q <= i_io.wdata[2:0];
      end
      if (wr_at(`DMC_IDX_ORGX_LO)) begin
        orgx_lo_q <= i_io.wdata;
      end
      if (wr_at(`DMC_IDX_ORGY_HI)) begin
        orgy_hi_q <= i_io.wdata[2:0];
      end
      if (wr_at(`DMC_IDX_ORGY_LO)) begin
        orgy_lo_q <= i_io.wdata;
      end
    end
  end

  // applying both axes at once avoids a cursor that tears across a move
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cursor_left_coordinate <= 11'h000;
      o_cursor_top_coordinate <= 11'h000;
    end else if (wr_at(`DMC_IDX_ORGY_HI)) begin
      o_cursor_left_coordinate <= {orgx_hi_q, orgx_lo_q};
      o_cursor_top_coordinate <= {i_io.wdata[2:0], orgy_lo_q};
    end
  end

  // ****************************************
  // storage start and pattern offsets
  // ****************************************
  logic [3:0] sta_hi_q;
  logic [7:0] sta_lo_q;
  logic [5:0] pat_x_q;
  logic [5:0] pat_y_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sta_hi_q <= 4'h0;
      sta_lo_q <= `DMC_RST_BYTE;
    end else begin
      if (wr_at(`DMC_IDX_STA_HI)) begin
        sta_hi_q <= i_io.wdata[3:0];
      end
      if (wr_at(`DMC_IDX_STA_LO)) begin
        sta_lo_q <= i_io.wdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pat_x_q <= 6'h00;
      pat_y_q <= 6'h00;
    end else begin
      if (wr_at(`DMC_IDX_PAT_X)) begin
        pat_x_q <= i_io.wdata[5:0];
      end
      if (wr_at(`DMC_IDX_PAT_Y)) begin
        pat_y_q <= i_io.wdata[5:0];
      end
    end
  end

  // ****************************************
  // colour stacks
  // ****************************************
  dmc_pkg::dmc_stack_cmd_t stack_cmd;
  logic [7:0] fg_rdata;
  logic [7:0] bg_rdata;

  assign stack_cmd.wr_fg = wr_at(`DMC_IDX_FG_STACK);
  assign stack_cmd.wr_bg = wr_at(`DMC_IDX_BG_STACK);
  assign stack_cmd.ptr_clr = acc_rd && (index_q == `DMC_IDX_CUR_MODE);
  assign stack_cmd.wdata = i_io.wdata;

  dmc_colour_stack u_stack (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_cmd(stack_cmd),
    .o_fg_rdata(fg_rdata),
    .o_bg_rdata(bg_rdata),
    .o_colour(o_colour)
  );

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = `DMC_RST_BYTE;
    unique case (index_q)
      `DMC_IDX_MODE_CTL: rd_mux = mode_ctl_q;
      `DMC_IDX_EXTENDED_DISPLAY_MODE: rd_mux = extended_display_mode_q;
      `DMC_IDX_CUR_MODE: rd_mux = cur_mode_q;
      `DMC_IDX_ORGX_HI: rd_mux = {5'h00, orgx_hi_q};
      `DMC_IDX_ORGX_LO: rd_mux = orgx_lo_q;
      `DMC_IDX_ORGY_HI: rd_mux = {5'h00, orgy_hi_q};
      `DMC_IDX_ORGY_LO: rd_mux = orgy_lo_q;
      `DMC_IDX_FG_STACK: rd_mux = fg_rdata;
      `DMC_IDX_BG_STACK: rd_mux = bg_rdata;
      `DMC_IDX_STA_HI: rd_mux = {4'h0, sta_hi_q};
      `DMC_IDX_STA_LO: rd_mux = sta_lo_q;
      `DMC_IDX_PAT_X: rd_mux = {2'h0, pat_x_q};
      `DMC_IDX_PAT_Y: rd_mux = {2'h0, pat_y_q};
      default: rd_mux = `DMC_RST_BYTE;
    endcase
  end

  // locked or foreign indices, except the lock register at 39, answer zero so the bank never leaks state
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_io_rdata <= `DMC_RST_BYTE;
      o_io_rd_ack <= 1'b0;
    end else begin
      o_io_rd_ack <= idx_rd || dat_rd;
      if (idx_rd) begin
        o_io_rdata <= index_q;
      end else if (dat_rd && index_q == `DMC_IDX_LOCK2) begin
        o_io_rdata <= lock2_q;
      end else if (acc_rd) begin
        o_io_rdata <= rd_mux;
      end else begin
        o_io_rdata <= `DMC_RST_BYTE;
      end
    end
  end

  // ****************************************
  // mode outputs
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_unlocked <= 1'b0;
      o_interlace_select <= 1'b0;
      o_pixel_clock_dual_edge <= 1'b0;
      o_dac_select_bit2 <= 1'b0;
      o_screen_width_bit8 <= 1'b0;
      o_sixteen_bit_colour_enable <= 1'b0;
      o_port_translate_enable <= 1'b0;
      o_enhanced_port <= `DMC_ENH_PORT;
      o_horizontal_count_double <= 1'b0;
    end else begin
      o_unlocked <= unlocked;
      o_interlace_select <= mode_ctl_q[`DMC_B_INTERLACE];
      o_pixel_clock_dual_edge <= extended_display_mode_q[`DMC_B_DUAL_EDGE];
      o_dac_select_bit2 <= (i_dac_select_ext == 2'h0) &&
                           extended_display_mode_q[`DMC_B_DAC_SEL2];
      o_screen_width_bit8 <= (i_screen_width_ext == 2'h0) &&
                             extended_display_mode_q[`DMC_B_WIDTH8];
      o_sixteen_bit_colour_enable <= extended_display_mode_q[`DMC_B_COLOUR16];
      o_port_translate_enable <= extended_display_mode_q[`DMC_B_PORT_XLATE];
      o_enhanced_port <= extended_display_mode_q[`DMC_B_PORT_XLATE] ?
                         (`DMC_ENH_PORT ^ `DMC_ENH_XOR) : `DMC_ENH_PORT;
      o_horizontal_count_double <= extended_display_mode_q[`DMC_B_HDOUBLE];
    end
  end

  // ****************************************
  // cursor control outputs
  // ****************************************
  logic stretch2;
  logic stretch3;

  assign stretch2 = cur_mode_q[`DMC_B_STRETCH2];
  assign stretch3 = cur_mode_q[`DMC_B_STRETCH3];

  // with both stretch bits set, triple width wins
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cursor_visible <= 1'b0;
      o_cursor_width_factor <= 2'h1;
      o_truecolour_use <= 1'b0;
    end else begin
      o_cursor_visible <= cur_mode_q[`DMC_B_CUR_EN] && i_enhanced_mode;
      if (stretch3) begin
        o_cursor_width_factor <= 2'h3;
      end else if (stretch2) begin
        o_cursor_width_factor <= 2'h2;
      end else begin
        o_cursor_width_factor <= 2'h1;
      end
      o_truecolour_use <= stretch2 || stretch3;
    end
  end

  // the pixel depth picks 256 or 512 byte blocks downstream; here only
  // the mode and the alignment the placement needs are held
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cursor_right_storage <= 1'b0;
      o_storage_align_error <= 1'b0;
      o_cursor_storage_start <= 12'h000;
      o_pattern_offset_horizontal <= 6'h00;
      o_pattern_offset_vertical <= 6'h00;
    end else begin
      o_cursor_right_storage <= cur_mode_q[`DMC_B_RIGHT_STORE];
      o_storage_align_error <= cur_mode_q[`DMC_B_RIGHT_STORE] &&
                               (sta_lo_q[1:0] != 2'h3);
      o_cursor_storage_start <= {sta_hi_q, sta_lo_q};
      o_pattern_offset_horizontal <= pat_x_q;
      o_pattern_offset_vertical <= pat_y_q;
    end
  end

  // ****************************************
  // cursor pins toward the video DAC
  // ****************************************
  // pins are released (oe_n high) unless external cursor mode claims them
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cursor_pixel_outputs <= 2'h0;
      o_cursor_pins_oe_n <= 1'b1;
    end else begin
      o_cursor_pins_oe_n <= !i_ext_cursor_enable;
      if (i_ext_cursor_enable && cur_mode_q[`DMC_B_REMAP]) begin
        o_cursor_pixel_outputs <= {i_odd_field, i_cursor_data_valid};
      end else if (i_ext_cursor_enable) begin
        o_cursor_pixel_outputs <= i_cursor_pixel_data;
      end else begin
        o_cursor_pixel_outputs <= 2'h0;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/dmc_regs_props.sv
// Purpose: port-level properties of the display mode and cursor register bank
// Assumes: sees only ports of dmc_regs; one clock domain
// Notes: the index byte is tracked here from host writes to the index port
`timescale 1ns/10ps
`default_nettype none

module dmc_regs_props (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire dmc_pkg::dmc_io_req_t i_io,
  input wire logic i_ext_cursor_enable,
  input wire logic o_io_rd_ack,
  input wire logic o_unlocked,
  input wire logic o_port_translate_enable,
  input wire logic [9:0] o_enhanced_port,
  input wire logic [1:0] o_cursor_width_factor,
  input wire logic o_truecolour_use,
  input wire logic o_cursor_right_storage,
  input wire logic o_storage_align_error,
  input wire logic [11:0] o_cursor_storage_start,
  input wire logic [10:0] o_cursor_top_coordinate,
  input wire logic [1:0] o_cursor_pixel_outputs,
  input wire logic o_cursor_pins_oe_n
);
  logic [7:0] idx_q;
  logic io_idx;
  logic io_dat;
  logic wr_data;
  assign io_idx = (i_io.addr == 16'h03B4) || (i_io.addr == 16'h03D4);
  assign io_dat = (i_io.addr == 16'h03B5) || (i_io.addr == 16'h03D5);
  assign wr_data = i_io.wr && io_dat;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) idx_q <= 8'h00;
    else if (i_io.wr && io_idx) idx_q <= i_io.wdata;
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_rd_ack_follows: assert property (i_io.rd && (io_idx || io_dat) |=> o_io_rd_ack)
    else $error("read strobe not answered next cycle");
  a_ack_has_cause: assert property (o_io_rd_ack |-> $past(i_io.rd))
    else $error("read ack without a read");
  a_unlock_key: assert property ($rose(o_unlocked) |->
    $past(wr_data && idx_q == 8'h39 && i_io.wdata[7:5] == 3'b101, 2))
    else $error("bank unlocked without the key");
  a_relock_cause: assert property ($fell(o_unlocked) && !$past(i_rst) |->
    $past(wr_data && idx_q == 8'h39, 2))
    else $error("bank locked without a lock write");
  a_port_decode: assert property (o_enhanced_port ==
    (o_port_translate_enable ? 10'h148 : 10'h2E8))
    else $error("enhanced port does not follow translate bit");
  a_stretch_use: assert property (o_cursor_width_factor != 2'h0 &&
    o_truecolour_use == (o_cursor_width_factor != 2'h1))
    else $error("stack colour use does not match stretch");
  a_align_flag: assert property (o_storage_align_error ==
    (o_cursor_right_storage && o_cursor_storage_start[1:0] != 2'b11))
    else $error("alignment flag wrong");
  a_top_apply: assert property (wr_data && o_unlocked && idx_q == 8'h48 |=>
    o_cursor_top_coordinate[10:8] == $past(i_io.wdata[2:0]))
    else $error("high y byte not applied");
  a_coord_hold: assert property (!$stable(o_cursor_top_coordinate) && !$past(i_rst) |->
    $past(wr_data && idx_q == 8'h48))
    else $error("cursor position moved without high y write");
  a_pin_enable: assert property (!$past(i_rst) |->
    o_cursor_pins_oe_n == !$past(i_ext_cursor_enable))
    else $error("cursor pin enable wrong");
  a_pins_idle: assert property (o_cursor_pins_oe_n |-> o_cursor_pixel_outputs == 2'b00)
    else $error("cursor pins not idle while released");
endmodule

bind dmc_regs dmc_regs_props u_props (.*);
`default_nettype wire

// File: tb/dmc_dac_model.sv
// Purpose: video converter end that receives the two cursor pins
// Assumes: pins are sampled on the rising clock edge
// Notes: released pins show the inverse of the last driven value
`timescale 1ns/10ps
`default_nettype none

module dmc_dac_model (
  input wire logic i_ref_clk,
  input wire logic [1:0] i_pins,
  input wire logic i_oe_n,
  output logic [1:0] o_seen
);
  logic [1:0] last_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_oe_n) last_q <= i_pins;
  end
  // no keeper on these lines, so a stale value must never look valid
  assign o_seen = i_oe_n ? ~last_q : i_pins;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench for the display mode and cursor register bank
// Assumes: inputs change on the falling clock edge
// Notes: read results are queued and compared when the ack appears
`timescale 1ns/10ps
`default_nettype none
`include "dmc_params.svh"

module testbench;
  logic i_ref_clk, i_rst, i_ext_cursor_enable, i_enhanced_mode, i_odd_field, i_cursor_data_valid;
  dmc_pkg::dmc_io_req_t i_io;
  logic [1:0] i_dac_select_ext, i_screen_width_ext, i_cursor_pixel_data;
  logic [1:0] o_cursor_width_factor, o_cursor_pixel_outputs, dac_seen, e;
  logic [7:0] o_io_rdata, v;
  logic o_io_rd_ack, o_unlocked, o_interlace_select, o_pixel_clock_dual_edge;
  logic o_dac_select_bit2, o_screen_width_bit8, o_sixteen_bit_colour_enable;
  logic o_port_translate_enable, o_horizontal_count_double, o_cursor_visible;
  logic o_truecolour_use, o_cursor_right_storage, o_storage_align_error, o_cursor_pins_oe_n;
  logic [9:0] o_enhanced_port;
  logic [10:0] o_cursor_left_coordinate, o_cursor_top_coordinate;
  logic [11:0] o_cursor_storage_start;
  logic [5:0] o_pattern_offset_horizontal, o_pattern_offset_vertical;
  dmc_pkg::dmc_colour_t o_colour;
  logic [7:0] exp_q[$];
  logic [7:0] cm [6] = '{8'h01, 8'h01, 8'h05, 8'h09, 8'h0D, 8'h31};
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  dmc_regs DUT (.*);
  dmc_dac_model u_dac (.i_ref_clk(i_ref_clk), .i_pins(o_cursor_pixel_outputs),
    .i_oe_n(o_cursor_pins_oe_n), .o_seen(dac_seen));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // host io cycles, back to back
  // ****************************************
  task automatic io(input logic wr, input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_io = {wr, rd, a, d};
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, 1'b0, 16'h03D4, idx);
    io(1'b1, 1'b0, 16'h03D5, d);
    io(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask

  task automatic rreg(input logic [7:0] idx, input logic [7:0] x);
    io(1'b1, 1'b0, 16'h03B4, idx);
    exp_q.push_back(x);
    io(1'b0, 1'b1, 16'h03B5, 8'h00);
    io(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask

  task automatic settle;
    repeat (2) @(negedge i_ref_clk);
  endtask

  always @(negedge i_ref_clk) begin
    if (o_io_rd_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("CHECK FAILED at %0t: read ack with nothing expected", $time);
      end else chk({40'h0, o_io_rdata}, {40'h0, exp_q.pop_front()});
    end
  end

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict;
    end
  end

  initial begin
    i_rst = 1'b1;
    i_io = '0;
    {i_dac_select_ext, i_screen_width_ext, i_cursor_pixel_data} = 6'h00;
    {i_ext_cursor_enable, i_enhanced_mode, i_odd_field, i_cursor_data_valid} = 4'h0;
    void'($urandom(28));
    repeat (4) @(negedge i_ref_clk);
    i_rst = 1'b0;
    chk({o_unlocked, o_cursor_pins_oe_n, o_cursor_width_factor, o_enhanced_port},
      {1'b0, 1'b1, 2'h1, 10'h2E8});
    // locked bank ignores writes and reads zero
    wreg(`DMC_IDX_EXTENDED_DISPLAY_MODE, 8'h08);
    settle;
    chk(o_sixteen_bit_colour_enable, 1'b0);
    rreg(`DMC_IDX_EXTENDED_DISPLAY_MODE, 8'h00);
    wreg(`DMC_IDX_LOCK2, 8'hA0);
    settle;
    chk(o_unlocked, 1'b1);
    wreg(`DMC_IDX_MODE_CTL, 8'h20);
    settle;
    chk(o_interlace_select, 1'b1);
    for (int k = 0; k < 6; k++) begin
      v = 8'($urandom()) & `DMC_MASK_EXTENDED_DISPLAY_MODE;
      i_dac_select_ext = 2'($urandom()) & {2{k[0]}};
      i_screen_width_ext = 2'($urandom()) & {2{k[1]}};
      wreg(`DMC_IDX_EXTENDED_DISPLAY_MODE, v);
      settle;
      chk(o_pixel_clock_dual_edge, v[0]);
      chk(o_dac_select_bit2, v[1] & (i_dac_select_ext == 2'h0));
      chk(o_screen_width_bit8, v[2] & (i_screen_width_ext == 2'h0));
      chk(o_sixteen_bit_colour_enable, v[3]);
      chk({o_port_translate_enable, o_enhanced_port}, {v[4], v[4] ? 10'h148 : 10'h2E8});
      chk(o_horizontal_count_double, v[7]);
      rreg(`DMC_IDX_EXTENDED_DISPLAY_MODE, v);
    end
    foreach (cm[k]) begin
      i_enhanced_mode = k[0];
      wreg(`DMC_IDX_CUR_MODE, cm[k]);
      settle;
      chk(o_cursor_visible, cm[k][0] & k[0]);
      chk(o_cursor_width_factor, cm[k][3] ? 2'h3 : cm[k][2] ? 2'h2 : 2'h1);
      chk({o_truecolour_use, o_cursor_right_storage}, {cm[k][2] | cm[k][3], cm[k][4]});
    end
    for (int k = 0; k < 4; k++) begin
      wreg(`DMC_IDX_CUR_MODE, k[0] ? 8'h30 : 8'h10);
      i_ext_cursor_enable = k[1];
      {i_odd_field, i_cursor_data_valid, i_cursor_pixel_data} = 4'($urandom());
      settle;
      e = !k[1] ? 2'h0 : k[0] ? {i_odd_field, i_cursor_data_valid} : i_cursor_pixel_data;
      chk({o_cursor_pins_oe_n, o_cursor_pixel_outputs}, {!k[1], e});
      if (k[1]) chk(dac_seen, e);
    end
    wreg(`DMC_IDX_STA_HI, 8'h0E);
    wreg(`DMC_IDX_STA_LO, 8'h5C);
    settle;
    chk({o_storage_align_error, o_cursor_storage_start}, {1'b1, 12'hE5C});
    wreg(`DMC_IDX_STA_LO, 8'h5F);
    settle;
    chk(o_storage_align_error, 1'b0);
    // position is staged until the high y byte lands
    wreg(`DMC_IDX_ORGX_HI, 8'h05);
    wreg(`DMC_IDX_ORGX_LO, 8'hAA);
    wreg(`DMC_IDX_ORGY_LO, 8'h33);
    settle;
    chk({o_cursor_left_coordinate, o_cursor_top_coordinate}, 22'h0);
    wreg(`DMC_IDX_ORGY_HI, 8'h06);
    settle;
    chk({o_cursor_left_coordinate, o_cursor_top_coordinate}, {11'h5AA, 11'h633});
    rreg(`DMC_IDX_CUR_MODE, 8'h30);
    wreg(`DMC_IDX_FG_STACK, 8'h11);
    wreg(`DMC_IDX_BG_STACK, 8'h22);
    wreg(`DMC_IDX_FG_STACK, 8'h33);
    settle;
    chk(o_colour, {24'h330011, 24'h002200});
    // leave the pointer on entry 1 so the clear on a mode read is visible
    wreg(`DMC_IDX_FG_STACK, 8'h44);
    rreg(`DMC_IDX_CUR_MODE, 8'h30);
    wreg(`DMC_IDX_FG_STACK, 8'h55);
    settle;
    chk(o_colour.fg, 24'h330055);
    rreg(`DMC_IDX_BG_STACK, 8'h22);
    wreg(`DMC_IDX_PAT_X, 8'h2A);
    wreg(`DMC_IDX_PAT_Y, 8'h15);
    settle;
    chk({o_pattern_offset_horizontal, o_pattern_offset_vertical}, {6'h2A, 6'h15});
    rreg(`DMC_IDX_PAT_Y, 8'h15);
    rreg(8'h44, 8'h00);
    wreg(`DMC_IDX_LOCK2, 8'h00);
    settle;
    chk(o_unlocked, 1'b0);
    wreg(`DMC_IDX_PAT_X, 8'h3F);
    rreg(`DMC_IDX_PAT_X, 8'h00);
    settle;
    chk(o_pattern_offset_horizontal, 6'h2A);
    chk(exp_q.size(), 0);
    give_verdict;
  end
endmodule
`default_nettype wire
